//--- adc_seq_regs.vh
// register offsets, field positions and timing counts of the conversion sequencer
`ifndef ADC_SEQ_REGS_VH
`define ADC_SEQ_REGS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CTRL0 8'hD8
`define OFS_REFPROG 8'hDA
`define OFS_RESULT 8'hD9
`define OFS_CHAN 8'hDC
`define OFS_IRQ_STAT 8'hE0
`define OFS_IRQ_CLR 8'hE1
`define OFS_IRQ_EN 8'hE2

// ----------------------------------------
// control 0 fields and reset values
// ----------------------------------------
`define CTRL0_CONT_BIT 3
`define CTRL0_BUSY_BIT 4
`define CTRL0_RESET 8'h00
`define REFPROG_RESET 8'h00
`define CHAN_RESET 4'h0
`define CHAN_LAST 4'hB

// ----------------------------------------
// timing in machine cycles; first trial code; settle count in fast clocks
// ----------------------------------------
`define SAMPLE_CYCLES 4'h7
`define TOTAL_CYCLES 4'hD
`define BIT_CYCLES 4'h6
`define FIRST_CYCLE 4'h1
`define TRIAL_MSB 8'h80
`define SETTLE_LAST 2'h3

`endif

//--- adc_conversion_sequencer.v
// conversion sequencer for an 8-bit successive approximation converter
// ----------------------------------------
// Behaviour
// - one of twelve channels converts to an 8-bit result by successive approximation
// - first seven machine cycles of each conversion sample the selected input
// - each conversion ends exactly thirteen machine cycles after it starts
// - software picks single-shot or continuous conversion
// - a finished conversion can raise an interrupt request
// - reference program low nibble sets lower level, high nibble upper level
// - step code n means n sixteenths of span; code zero gives full range
// ----------------------------------------
`timescale 1ns/1ps
`include "adc_seq_regs.vh"

module adc_conversion_sequencer #(
    parameter MC_DIV = 12
) (
    // clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // register port
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rdata_out,
    // analog front end
    input wire comp_in,
    output reg [3:0] chan_sel_out,
    output reg sample_out,
    output reg [7:0] dac_code_out,
    output reg [3:0] internal_lower_ref_out,
    output reg [3:0] internal_upper_ref_out,
    // interrupt
    output reg irq_out
);

    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_SAMPLE = 3'b010;
    localparam ST_APPROX = 3'b100;

    reg [2:0] state_q;
    reg [7:0] mc_cnt_q;
    reg mc_tick_q;
    reg [3:0] cyc_q;
    reg [7:0] sar_q;
    reg [7:0] trial_q;
    reg [7:0] result_q;
    reg cont_q;
    reg [3:0] chan_q;
    reg [7:0] refprog_q;
    reg [7:0] ctrl_misc_q;
    reg irq_stat_q;
    reg irq_en_q;
    reg comp_meta_q;
    reg comp_sync_q;
    reg start_pend_q;
    reg done_q;
    reg [1:0] settle_q;
    reg [2:0] state_d;
    reg [3:0] cyc_d;
    reg start_conv;
    reg load_trial;
    reg finish;

    wire mc_wrap = (mc_cnt_q == MC_DIV[7:0] - 8'h01);
    wire wr_ctrl = wr_in && (addr_in == `OFS_CTRL0);

    // ----------------------------------------
    // machine cycle enable and comparator sync
    // ----------------------------------------
    // one fast clock in every MC_DIV marks a machine cycle
    // limitation: MC_DIV below 6 leaves too few clocks for eight trials
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            mc_cnt_q <= 8'h00;
            mc_tick_q <= 1'b0;
        end else begin
            mc_cnt_q <= mc_wrap ? 8'h00 : mc_cnt_q + 8'h01;
            mc_tick_q <= mc_wrap;
        end
    end

    // comparator is asynchronous to this clock: two flops first
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            comp_meta_q <= 1'b0;
            comp_sync_q <= 1'b0;
        end else begin
            comp_meta_q <= comp_in;
            comp_sync_q <= comp_meta_q;
        end
    end

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    wire wr_refprog = wr_in && (addr_in == `OFS_REFPROG);
    wire wr_chan = wr_in && (addr_in == `OFS_CHAN);
    wire wr_irq_en = wr_in && (addr_in == `OFS_IRQ_EN);
    wire wr_irq_clr = wr_in && (addr_in == `OFS_IRQ_CLR);
    wire chan_ok = (wdata_in[3:0] <= `CHAN_LAST);

    // any write to control 0 requests a conversion
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            cont_q <= 1'b0;
            ctrl_misc_q <= `CTRL0_RESET;
        end else if (wr_ctrl) begin
            cont_q <= wdata_in[`CTRL0_CONT_BIT];
            ctrl_misc_q <= wdata_in;
        end
    end

    // codes are taken as written; a write mid-conversion is not blocked
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            refprog_q <= `REFPROG_RESET;
        end else if (wr_refprog) begin
            refprog_q <= wdata_in;
        end
    end

    // out-of-range channel numbers are dropped, the old one stays
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            chan_q <= `CHAN_RESET;
        end else if (wr_chan && chan_ok) begin
            chan_q <= wdata_in[3:0];
        end
    end

    // only bit 0 is kept
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_en_q <= 1'b0;
        end else if (wr_irq_en) begin
            irq_en_q <= wdata_in[0];
        end
    end

    // a start that lands during a conversion waits for its end
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            start_pend_q <= 1'b0;
        end else if (start_conv) begin
            start_pend_q <= 1'b0;
        end else if (wr_ctrl) begin
            start_pend_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always @* begin
        state_d = state_q;
        cyc_d = cyc_q;
        start_conv = 1'b0;
        load_trial = 1'b0;
        finish = 1'b0;
        if (mc_tick_q) begin
            case (state_q)
                ST_IDLE: begin
                    if (start_pend_q) begin
                        start_conv = 1'b1;
                        state_d = ST_SAMPLE;
                        cyc_d = `FIRST_CYCLE;
                    end
                end
                ST_SAMPLE: begin
                    cyc_d = cyc_q + 4'h1;
                    if (cyc_q == `SAMPLE_CYCLES) begin
                        state_d = ST_APPROX;
                        load_trial = 1'b1;
                    end
                end
                ST_APPROX: begin
                    cyc_d = cyc_q + 4'h1;
                    if (cyc_q == `TOTAL_CYCLES) begin
                        finish = 1'b1;
                        if (cont_q && !start_pend_q) begin
                            state_d = ST_SAMPLE;
                            cyc_d = `FIRST_CYCLE;
                        end else begin
                            state_d = ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    // next state is worked out above, registered here
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_q <= ST_IDLE;
            cyc_q <= 4'h0;
        end else begin
            state_q <= state_d;
            cyc_q <= cyc_d;
        end
    end

    // result is updated only at the last machine cycle
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            result_q <= 8'h00;
            done_q <= 1'b0;
        end else begin
            done_q <= finish;
            if (finish) begin
                result_q <= sar_q;
            end
        end
    end

    // ----------------------------------------
    // bit trials
    // ----------------------------------------
    // each trial waits for the code to reach the comparator and the sync pair
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            sar_q <= 8'h00;
            trial_q <= 8'h00;
            settle_q <= 2'h0;
        end else if (load_trial) begin
            sar_q <= 8'h00;
            trial_q <= `TRIAL_MSB;
            settle_q <= 2'h0;
        end else if (state_q == ST_APPROX && trial_q != 8'h00) begin
            settle_q <= settle_q + 2'h1;
            if (settle_q == `SETTLE_LAST) begin
                if (comp_sync_q) begin
                    sar_q <= sar_q | trial_q;
                end
                trial_q <= trial_q >> 1;
            end
        end
    end

    // set wins over clear
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_stat_q <= 1'b0;
        end else if (done_q) begin
            irq_stat_q <= 1'b1;
        end else if (wr_irq_clr && wdata_in[0]) begin
            irq_stat_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // outputs and read port
    // ----------------------------------------
    wire busy = (state_q != ST_IDLE);
    reg [7:0] rdata_d;

    // channel goes out registered, changes only between writes
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            chan_sel_out <= `CHAN_RESET;
        end else begin
            chan_sel_out <= chan_q;
        end
    end

    // high through the whole sample phase
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            sample_out <= 1'b0;
        end else begin
            sample_out <= (state_q == ST_SAMPLE);
        end
    end

    // the trial code shows the bit under test on top of the bits kept
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            dac_code_out <= 8'h00;
        end else begin
            dac_code_out <= sar_q | trial_q;
        end
    end

    // code n is n sixteenths of span; zero upper code means full scale
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            internal_lower_ref_out <= 4'h0;
            internal_upper_ref_out <= 4'h0;
        end else begin
            internal_lower_ref_out <= refprog_q[3:0];
            internal_upper_ref_out <= refprog_q[7:4];
        end
    end

    // level request while an enabled status bit is set
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= irq_stat_q && irq_en_q;
        end
    end

    // read data stand for one cycle only, zero otherwise
    always @* begin
        rdata_d = 8'h00;
        if (rd_in) begin
            if (addr_in == `OFS_CTRL0) begin
                rdata_d = {ctrl_misc_q[7:5], busy, cont_q, ctrl_misc_q[2:0]};
            end else if (addr_in == `OFS_RESULT) begin
                rdata_d = result_q;
            end else if (addr_in == `OFS_REFPROG) begin
                rdata_d = refprog_q;
            end else if (addr_in == `OFS_CHAN) begin
                rdata_d = {4'h0, chan_q};
            end else if (addr_in == `OFS_IRQ_STAT) begin
                rdata_d = {7'h00, irq_stat_q};
            end else if (addr_in == `OFS_IRQ_EN) begin
                rdata_d = {7'h00, irq_en_q};
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= rdata_d;
        end
    end

endmodule

//--- adc_seq_monitor.sv
// port assertions for the conversion sequencer
`timescale 1ns/1ps
`include "adc_seq_regs.vh"
module adc_seq_monitor #(
    parameter MC_DIV = 12
) (
    // clock, reset, register port
    input wire clk_in,
    input wire rst_n_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] rdata_out,
    // converter side
    input wire [3:0] chan_sel_out,
    input wire sample_out,
    input wire [3:0] internal_lower_ref_out,
    input wire [3:0] internal_upper_ref_out,
    input wire irq_out
);
    localparam int CONV = 13 * MC_DIV;
    localparam int SMAX = MC_DIV + 2;
    localparam int APX = 6 * MC_DIV;
    reg [11:0] run_q;
    reg [11:0] hi_q;
    reg [11:0] apx_q;
    reg [11:0] wr_q;
    reg cont_q;
    reg [7:0] ref_q;
    wire ctl_wr = wr_in && addr_in == `OFS_CTRL0;
    // ----------------------------------------
    // helper counters; run_q, apx_q and wr_q saturate so they never wrap into a match, hi_q counts only while sampling
    // ----------------------------------------
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            run_q <= 12'hFFF;
            apx_q <= 12'hFFF;
            hi_q <= 12'h000;
            wr_q <= 12'hFFF;
            cont_q <= 1'b0;
            ref_q <= 8'h00;
        end else begin
            run_q <= $rose(sample_out) ? 12'h000 : run_q + {11'h000, run_q != 12'hFFF};
            hi_q <= sample_out ? hi_q + 12'h001 : 12'h000;
            apx_q <= $fell(sample_out) ? 12'h000 : apx_q + {11'h000, apx_q != 12'hFFF};
            wr_q <= ctl_wr ? 12'h000 : wr_q + {11'h000, wr_q != 12'hFFF};
            if (ctl_wr) cont_q <= wdata_in[`CTRL0_CONT_BIT];
            if (wr_in && addr_in == `OFS_REFPROG) ref_q <= wdata_in;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    chk_chan_range: assert property (chan_sel_out <= `CHAN_LAST)
        else $error("channel select beyond last channel");
    chk_sample_len: assert property ($fell(sample_out) |-> hi_q == 7 * MC_DIV)
        else $error("sample phase length wrong");
    // only a start from idle is due within one machine cycle
    chk_start_sample: assert property (ctl_wr && run_q >= CONV |-> ##[1:SMAX] sample_out)
        else $error("no sample phase after start");
    // approx part after the checked sample part makes up the whole conversion
    chk_conv_len: assert property ($rose(irq_out) |-> apx_q == APX)
        else $error("conversion length wrong");
    chk_single_stop: assert property ($rose(sample_out) && !cont_q |-> wr_q <= SMAX)
        else $error("single mode restarted by itself");
    chk_cont_restart: assert property (run_q == CONV + MC_DIV && wr_q > CONV |-> !cont_q)
        else $error("continuous mode did not restart");
    chk_read_pulse: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data outside its cycle");
    chk_ref_prog: assert property (wr_in && addr_in == `OFS_REFPROG |->
        ##2 {internal_upper_ref_out, internal_lower_ref_out} == ref_q)
        else $error("reference levels do not follow program");
    cover property ($rose(irq_out));
    cover property ($rose(sample_out) && cont_q);
    cover property (rd_in && addr_in == `OFS_RESULT);
endmodule
bind adc_conversion_sequencer adc_seq_monitor #(.MC_DIV(MC_DIV)) mon (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .chan_sel_out(chan_sel_out),
    .sample_out(sample_out), .internal_lower_ref_out(internal_lower_ref_out),
    .internal_upper_ref_out(internal_upper_ref_out), .irq_out(irq_out));

//--- adc_front_model.sv
// multiplexer and comparator model of the analog side
`timescale 1ns/1ps
module adc_front_model (
    input wire [3:0] chan_sel_in,
    input wire [7:0] dac_code_in,
    output wire comp_out
);
    // levels in half steps, so no trial code ever ties with an odd level; the reset level 9'h100 ties with code 8'h80
    reg [8:0] level [0:11];
    initial for (int i = 0; i < 12; i++) level[i] = 9'h100;
    assign comp_out = chan_sel_in <= 4'hB && level[chan_sel_in] > {dac_code_in, 1'b0};
endmodule

//--- tb_top.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`include "adc_seq_regs.vh"
module tb_top;
    localparam int MC = 10;
    reg clk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg [7:0] addr_in = 8'h00;
    reg [7:0] wdata_in = 8'h00;
    reg wr_in = 1'b0;
    reg rd_in = 1'b0;
    wire [7:0] rdata_out, dac_code_out;
    wire [3:0] chan_sel_out, lo_ref, hi_ref;
    wire comp_in, sample_out, irq_out;
    int err_total = 0;
    int total_checks = 0;
    int n;
    always #2 clk_in = ~clk_in;
    adc_conversion_sequencer #(.MC_DIV(MC)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .comp_in(comp_in), .chan_sel_out(chan_sel_out),
        .sample_out(sample_out), .dac_code_out(dac_code_out), .internal_lower_ref_out(lo_ref),
        .internal_upper_ref_out(hi_ref), .irq_out(irq_out));
    adc_front_model fe (.chan_sel_in(chan_sel_out), .dac_code_in(dac_code_out), .comp_out(comp_in));
    task chk(input string what, input [7:0] exp, input [7:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task rc(input [7:0] a, input [7:0] e, input string what);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk(what, e, rdata_out);
    endtask
    // bounded wait; counts whole cycles from the call
    task wait_irq;
        n = 0;
        while (irq_out !== 1'b1 && n < 300) begin
            @(negedge clk_in);
            n++;
        end
    endtask
    task t_reset;
        rc(`OFS_CTRL0, `CTRL0_RESET, "ctrl0");
        rc(`OFS_CHAN, 8'h00, "chan");
        rc(`OFS_IRQ_EN, 8'h00, "irq en");
        rc(8'h10, 8'h00, "unmapped");
        chk("refs", 8'h00, {hi_ref, lo_ref});
    endtask
    task t_ref;
        wr(`OFS_REFPROG, 8'hC4);
        rc(`OFS_REFPROG, 8'hC4, "refprog");
        chk("refs", 8'hC4, {hi_ref, lo_ref});
        wr(`OFS_REFPROG, 8'h00);
        rc(`OFS_REFPROG, 8'h00, "full range");
    endtask
    task t_single;
        fe.level[5] = 9'h14B;
        wr(`OFS_IRQ_EN, 8'h01);
        wr(`OFS_CHAN, 8'h05);
        wr(`OFS_CHAN, 8'h0C);
        rc(`OFS_CHAN, 8'h05, "chan refused");
        chk("chan sel", 8'h05, {4'h0, chan_sel_out});
        wr(`OFS_CTRL0, 8'h00);
        wait_irq;
        chk("conv time", 8'h01, {7'h00, n >= 13 * MC && n <= 14 * MC + 3});
        rc(`OFS_RESULT, 8'hA5, "result");
        chk("dac code", 8'hA5, dac_code_out);
        rc(`OFS_IRQ_STAT, 8'h01, "status");
        wr(`OFS_IRQ_CLR, 8'h01);
        rc(`OFS_IRQ_STAT, 8'h00, "cleared");
        chk("irq low", 8'h00, {7'h00, irq_out});
        repeat (15 * MC) @(posedge clk_in);
        chk("stopped", 8'h00, {7'h00, sample_out});
    endtask
    task t_cont;
        fe.level[11] = 9'h1FF;
        wr(`OFS_CHAN, 8'h0B);
        wr(`OFS_CTRL0, 8'h08);
        wait_irq;
        rc(`OFS_RESULT, 8'hFF, "top code");
        rc(`OFS_CTRL0, 8'h18, "busy cont");
        fe.level[11] = 9'h001;
        wr(`OFS_IRQ_CLR, 8'h01);
        rc(`OFS_IRQ_STAT, 8'h00, "cleared");
        wait_irq;
        chk("restart", 8'h01, {7'h00, n < 14 * MC});
        rc(`OFS_RESULT, 8'h00, "bottom code");
        wr(`OFS_IRQ_EN, 8'h00);
        wr(`OFS_IRQ_CLR, 8'h01);
        repeat (14 * MC) @(posedge clk_in);
        rc(`OFS_IRQ_STAT, 8'h01, "masked status");
        chk("irq masked", 8'h00, {7'h00, irq_out});
        wr(`OFS_CTRL0, 8'h00);
    endtask
    task test_done;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_reset;
        t_ref;
        t_single;
        t_cont;
        test_done;
    end
    initial begin
        #40000;
        err_total++;
        test_done;
    end
endmodule
